/* File: core/prf_pkg.sv */
package prf_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int REC_PERIOD_S = 1;
  localparam int SEC_CYCLES   = CLK_HZ * REC_PERIOD_S;
  localparam int BAUD_FAST    = 9600;
  localparam int BAUD_SLOW    = 4800;
  // nearest whole cycle per bit; the error stays far below a uart's margin
  localparam int BIT_CYC_FAST = (CLK_HZ + BAUD_FAST / 2) / BAUD_FAST;
  localparam int BIT_CYC_SLOW = (CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW;
  localparam int DATA_BITS    = 8;
  localparam int BUF_DEPTH    = 2;

  // ****************************************************************
  // framing bytes
  // ****************************************************************
  localparam logic [7:0] DLE_BYTE  = 8'h10;
  localparam logic [7:0] ETX_BYTE  = 8'h03;
  localparam logic [7:0] TYPE_POS  = 8'h33;
  localparam logic [7:0] TYPE_MEAS = 8'h34;
  localparam logic [7:0] LEN_POS   = 8'h40;
  localparam logic [7:0] LEN_MEAS  = 8'he2;

  // ****************************************************************
  // payload fields
  // ****************************************************************
  localparam logic [7:0] FIX_LO_IDX   = 8'h10;
  localparam logic [7:0] FIX_HI_IDX   = 8'h11;
  localparam logic [2:0] FIX_MAX      = 3'h5;
  localparam logic [2:0] FIX_NONE     = 3'h0;
  localparam logic [7:0] SV_BASE_IDX  = 8'h0a;
  localparam logic [4:0] SV_REC_LEN   = 5'h12;
  localparam logic [4:0] SV_SLIP_OFS  = 5'h0e;
  localparam logic [4:0] SV_ID_OFS    = 5'h10;
  localparam logic [4:0] SV_VALID_OFS = 5'h11;
  localparam logic [7:0] SVID_MASK    = 8'h1f;

  typedef enum logic {PRF_REC_POS, PRF_REC_MEAS} prf_rec_t;

endpackage

/* File: core/prf_byte_if.sv */
interface prf_byte_if;
  logic [prf_pkg::DATA_BITS-1:0] data;
  logic                          valid;
  logic                          ready;
  logic [15:0]                   bit_cyc;

  modport src (output data, output valid, output bit_cyc, input ready);
  modport snk (input data, input valid, input bit_cyc, output ready);
endinterface

/* File: core/prf_uart_tx.sv */
module prf_uart_tx #(
  parameter int W     = prf_pkg::DATA_BITS,
  parameter int DEPTH = prf_pkg::BUF_DEPTH
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // byte stream in
  prf_byte_if.snk   in_if,
  // serial line
  output logic      txd
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int BW = $clog2(W + 3);

  // ****************************************************************
  // two-entry buffer
  // ****************************************************************
  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic [W+1:0]  shift_r;
  logic [BW-1:0] bits_r;
  logic [15:0]   cyc_r;
  logic [15:0]   bit_cyc_r;
  logic          txd_r;
  wire           push = in_if.valid && in_if.ready;
  wire           pop  = !busy_r && (cnt_r != '0);
  wire           bit_end = busy_r && (cyc_r == 16'h0000);

  // the framer stalls on this, so a slow line never drops a byte
  assign in_if.ready = (cnt_r != CW'(DEPTH));
  assign txd = txd_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_if.data;
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  // ****************************************************************
  // shifter: start, eight data bits lsb first, stop, no parity
  // ****************************************************************
  // the bit time is caught per character, so a rate change never
  // splits one character across two rates
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r    <= 1'b0;
      txd_r     <= 1'b1;
      shift_r   <= '1;
      bits_r    <= '0;
      cyc_r     <= 16'h0000;
      bit_cyc_r <= 16'h0000;
    end else if (pop) begin
      busy_r    <= 1'b1;
      shift_r   <= {1'b1, mem_r[rp_r], 1'b0}; // R2
      txd_r     <= 1'b0;
      bits_r    <= BW'(W + 1);
      cyc_r     <= in_if.bit_cyc - 16'h0001;
      bit_cyc_r <= in_if.bit_cyc;
    end else if (bit_end) begin
      if (bits_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        txd_r   <= shift_r[1];
        shift_r <= {1'b1, shift_r[W+1:1]};
        bits_r  <= bits_r - BW'(1);
        cyc_r   <= bit_cyc_r - 16'h0001;
      end
    end else if (busy_r) begin
      cyc_r <= cyc_r - 16'h0001;
    end
  end

  a_start_low: // R2
    assert property (@(posedge clk) disable iff (srst)
      (busy_r && !$past(busy_r)) |-> !txd_r)
    else $error("character did not open with a low start bit");
  a_stop_high: // R2
    assert property (@(posedge clk) disable iff (srst)
      (busy_r && bits_r == '0) |-> txd_r)
    else $error("stop bit not high");
  a_buf_full:
    assert property (@(posedge clk) disable iff (srst)
      (cnt_r == CW'(DEPTH)) |=> (cnt_r <= CW'(DEPTH)))
    else $error("buffer count ran past its depth");
  c_buf_fill:
    cover property (@(posedge clk) disable iff (srst)
      cnt_r == CW'(DEPTH));
endmodule

/* File: core/prf_framer.sv */
// Operation
// R1: each phase-mode second send a position then a measurement record
// R2: line runs 9600 baud by default, 8 data bits, no parity
// R3: record opens with 0x10, then type byte, length byte, then payload
// R4: position type 0x33 length 0x40; measurement type 0x34 length 0xe2
// R5: payload followed by checksum, 0x10, and closing 0x03
// R6: checksum makes the byte sum between delimiters zero modulo 256
// R7: receiver deframes with data, delimiter and end states
// R8: receiver in end state drops bytes until a 0x10 arrives
// R9: receiver queue of 256 bytes, index wraps past 255
// R10: correction data arriving switches the output rate to its rate
// R11: correction data comes at 9600 or 4800 baud, never slower
// R12: fix code 0..5 only; 6 and above are never sent
// R13: slip and valid bytes: zero means no or invalid, else yes
// R14: receiver converts phase by times 360 over 2048
// R15: satellite number byte lies in 0..31
// R16: text sentence output stays off during phase mode
// R17: a 0x10 in type, length, payload or checksum is sent twice
module prf_framer #(
  parameter int SEC_CYCLES   = prf_pkg::SEC_CYCLES,
  parameter int BIT_CYC_FAST = prf_pkg::BIT_CYC_FAST,
  parameter int BIT_CYC_SLOW = prf_pkg::BIT_CYC_SLOW
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // mode and navigation state
  input  wire logic       phase_mode,
  input  wire logic [2:0] fix_code,
  // correction input status
  input  wire logic       corr_seen,
  input  wire logic       corr_slow,
  // payload source
  output logic            pay_rd,
  output logic            pay_rec,
  output logic [7:0]      pay_idx,
  input  wire logic [7:0] pay_data,
  // status
  output logic            text_en,
  output logic            rec_done,
  // serial line
  output logic            txd
);
  typedef enum {S_IDLE, S_DLE1, S_TYPE, S_LEN, S_RD, S_WT, S_CAP, S_PAY,
                S_CKS, S_DLE2, S_ETX} prf_state_t;

  // ****************************************************************
  // state
  // ****************************************************************
  prf_state_t        st_r;
  prf_state_t        st_nxt;
  prf_pkg::prf_rec_t rec_r;
  logic [7:0]        dat_r;
  logic              vld_r;
  logic              dup_r;
  logic [7:0]        sum_r;
  logic [7:0]        idx_r;
  logic [4:0]        svo_r;
  logic [7:0]        pay_q_r;
  logic              pend_r;
  logic [31:0]       sec_cnt_r;
  logic [15:0]       baud_r;
  logic              pay_rd_r;
  logic              pay_rec_r;
  logic [7:0]        pay_idx_r;
  logic              text_en_r;
  logic              rec_done_r;

  prf_byte_if byte_if ();

  // ****************************************************************
  // decode
  // ****************************************************************
  wire        is_meas  = (rec_r == prf_pkg::PRF_REC_MEAS);
  wire [7:0]  type_b   = is_meas ? prf_pkg::TYPE_MEAS : prf_pkg::TYPE_POS; // R4
  wire [7:0]  len_b    = is_meas ? prf_pkg::LEN_MEAS : prf_pkg::LEN_POS; // R4
  wire [7:0]  cks_b    = 8'h00 - sum_r; // R6
  wire [2:0]  fix_ok   = (fix_code > prf_pkg::FIX_MAX) ?
                         prf_pkg::FIX_NONE : fix_code; // R12
  wire        in_sv    = is_meas && (idx_r >= prf_pkg::SV_BASE_IDX);
  wire        pay_last = (idx_r == len_b - 8'h01);
  wire        tick     = (sec_cnt_r == 32'(SEC_CYCLES - 1));
  wire        start    = (st_r == S_IDLE) && pend_r && phase_mode;
  wire        emit     = (st_r == S_DLE1) || (st_r == S_TYPE) ||
                         (st_r == S_LEN) || (st_r == S_PAY) ||
                         (st_r == S_CKS) || (st_r == S_DLE2) ||
                         (st_r == S_ETX);
  wire        stuffable = (st_r == S_TYPE) || (st_r == S_LEN) ||
                          (st_r == S_PAY) || (st_r == S_CKS);
  wire [7:0]  cur_byte =
      (st_r == S_TYPE) ? type_b :
      (st_r == S_LEN)  ? len_b :
      (st_r == S_PAY)  ? pay_q_r :
      (st_r == S_CKS)  ? cks_b :
      (st_r == S_ETX)  ? prf_pkg::ETX_BYTE : prf_pkg::DLE_BYTE; // R3 R5
  wire        load  = emit && (!vld_r || byte_if.ready);
  // a second copy keeps the receiver's deframer in its data state
  wire        again = load && stuffable && !dup_r &&
                      (cur_byte == prf_pkg::DLE_BYTE); // R17
  wire        adv   = load && !again;

  // payload fields the framer owns are forced into their legal range
  function automatic logic [7:0] prf_fix_byte(
    input logic       meas,
    input logic       sv,
    input logic [7:0] idx,
    input logic [4:0] svo,
    input logic [7:0] raw,
    input logic [2:0] fix
  );
    logic [7:0] b;
    b = raw;
    if (!meas && idx == prf_pkg::FIX_LO_IDX) begin
      b = {5'h00, fix}; // R12
    end else if (!meas && idx == prf_pkg::FIX_HI_IDX) begin
      b = 8'h00;
    end else if (sv && (svo == prf_pkg::SV_SLIP_OFS ||
                        svo == prf_pkg::SV_VALID_OFS)) begin
      b = (raw != 8'h00) ? 8'h01 : 8'h00; // R13
    end else if (sv && svo == prf_pkg::SV_ID_OFS) begin
      b = raw & prf_pkg::SVID_MASK; // R15
    end
    return b;
  endfunction

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE:  if (start) st_nxt = S_DLE1; // R1
      S_DLE1:  if (adv) st_nxt = S_TYPE;
      S_TYPE:  if (adv) st_nxt = S_LEN;
      S_LEN:   if (adv) st_nxt = S_RD;
      S_RD:    st_nxt = S_WT;
      S_WT:    st_nxt = S_CAP;
      S_CAP:   st_nxt = S_PAY;
      S_PAY:   if (adv) st_nxt = pay_last ? S_CKS : S_RD;
      S_CKS:   if (adv) st_nxt = S_DLE2;
      S_DLE2:  if (adv) st_nxt = S_ETX;
      S_ETX:   if (adv) st_nxt = is_meas ? S_IDLE : S_DLE1; // R1
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r  <= S_IDLE;
      rec_r <= prf_pkg::PRF_REC_POS;
      vld_r <= 1'b0;
      dat_r <= 8'h00;
      dup_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      vld_r <= load | (vld_r & ~byte_if.ready);
      if (load) begin
        dat_r <= cur_byte;
        dup_r <= again;
      end
      if (start) begin
        rec_r <= prf_pkg::PRF_REC_POS;
      end else if (st_r == S_ETX && adv) begin
        rec_r <= prf_pkg::PRF_REC_MEAS; // R1
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sum_r   <= 8'h00;
      idx_r   <= 8'h00;
      svo_r   <= 5'h00;
      pay_q_r <= 8'h00;
    end else begin
      if (st_r == S_DLE1) begin
        sum_r <= 8'h00;
        idx_r <= 8'h00;
        svo_r <= 5'h00;
      end else if (adv && stuffable) begin
        sum_r <= sum_r + cur_byte; // R6
      end
      if (st_r == S_PAY && adv) begin
        idx_r <= idx_r + 8'h01;
        if (in_sv) begin
          svo_r <= (svo_r == prf_pkg::SV_REC_LEN - 5'h01) ?
                   5'h00 : svo_r + 5'h01;
        end
      end
      if (st_r == S_CAP) begin
        pay_q_r <= prf_fix_byte(is_meas, in_sv, idx_r, svo_r, pay_data,
                                fix_ok);
      end
    end
  end

  // ****************************************************************
  // cadence, rate and ports
  // ****************************************************************
  // a second that ends while the previous pair is still on the line
  // is held, not dropped; the set beats the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      sec_cnt_r  <= 32'h0000_0000;
      pend_r     <= 1'b0;
      baud_r     <= 16'(BIT_CYC_FAST); // R2
      pay_rd_r   <= 1'b0;
      pay_rec_r  <= 1'b0;
      pay_idx_r  <= 8'h00;
      text_en_r  <= 1'b1;
      rec_done_r <= 1'b0;
    end else begin
      sec_cnt_r  <= tick ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
      pend_r     <= (tick & phase_mode) | (pend_r & ~start); // R1
      if (corr_seen) begin
        baud_r <= corr_slow ? 16'(BIT_CYC_SLOW) : 16'(BIT_CYC_FAST); // R10
      end
      pay_rd_r   <= (st_r == S_RD);
      if (st_r == S_RD) begin
        pay_rec_r <= is_meas;
        pay_idx_r <= idx_r;
      end
      text_en_r  <= ~phase_mode; // R16
      rec_done_r <= (st_r == S_ETX) && adv;
    end
  end

  assign byte_if.data    = dat_r;
  assign byte_if.valid   = vld_r;
  assign byte_if.bit_cyc = baud_r;
  assign pay_rd   = pay_rd_r;
  assign pay_rec  = pay_rec_r;
  assign pay_idx  = pay_idx_r;
  assign text_en  = text_en_r;
  assign rec_done = rec_done_r;

  prf_uart_tx prf_uart_tx_inst (
    .clk   (clk),
    .srst  (srst),
    .in_if (byte_if),
    .txd   (txd)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sec_start: // R1
    assert property (@(posedge clk) disable iff (srst)
      start |=> (st_r == S_DLE1) && !is_meas)
    else $error("pending second did not open a position record");
  a_meas_next: // R1
    assert property (@(posedge clk) disable iff (srst)
      (st_r == S_ETX && adv && !is_meas) |=> (st_r == S_DLE1) && is_meas)
    else $error("measurement record did not follow position record");
  a_open_delim: // R3
    assert property (@(posedge clk) disable iff (srst)
      (st_r == S_TYPE && $past(st_r) == S_DLE1) |-> (dat_r == 8'h10))
    else $error("record did not open with the delimiter");
  a_type_len: // R4
    assert property (@(posedge clk) disable iff (srst)
      (st_r == S_LEN && load) |=> (dat_r == (is_meas ? 8'he2 : 8'h40)) &&
      ($past(dat_r) == (is_meas ? 8'h34 : 8'h33) || $past(dat_r) == 8'h10))
    else $error("wrong type or length byte");
  a_close_seq: // R5
    assert property (@(posedge clk) disable iff (srst)
      (st_r == S_ETX && adv) |=> (dat_r == 8'h03) && rec_done)
    else $error("record not closed by 0x03");
  a_sum_zero: // R6
    assert property (@(posedge clk) disable iff (srst)
      (st_r == S_DLE2 && $past(st_r) == S_CKS) |-> (sum_r == 8'h00))
    else $error("checksum leaves a non-zero sum");
  a_dle_twice: // R17
    assert property (@(posedge clk) disable iff (srst)
      again |=> dup_r && (st_r == $past(st_r)) && (dat_r == 8'h10))
    else $error("delimiter value not repeated");
  a_rate_switch: // R10
    assert property (@(posedge clk) disable iff (srst)
      corr_seen |=> baud_r == (($past(corr_slow)) ?
                    16'(BIT_CYC_SLOW) : 16'(BIT_CYC_FAST)))
    else $error("rate did not follow correction input");
  a_fix_range: // R12
    assert property (@(posedge clk) disable iff (srst)
      (st_r == S_PAY && !is_meas && idx_r == 8'h10) |-> pay_q_r <= 8'h05)
    else $error("fix code out of range");
  a_svid_range: // R15
    assert property (@(posedge clk) disable iff (srst)
      (st_r == S_PAY && in_sv && svo_r == 5'h10) |-> pay_q_r <= 8'h1f)
    else $error("satellite number above 31");
  a_text_off: // R16
    assert property (@(posedge clk) disable iff (srst)
      phase_mode [*2] |-> !text_en)
    else $error("text output on in phase mode");

  c_pair_done:
    cover property (@(posedge clk) disable iff (srst)
      rec_done && is_meas);
  c_dle_stuffed:
    cover property (@(posedge clk) disable iff (srst) again);
  c_slow_rate:
    cover property (@(posedge clk) disable iff (srst)
      corr_seen && corr_slow);
  c_stall:
    cover property (@(posedge clk) disable iff (srst)
      vld_r && !byte_if.ready);
endmodule

/* File: sim/prf_host_model.sv */
// ****************************************************************
// host side: serial receiver and record deframer
// ****************************************************************
module prf_host_model (
  // clock
  input  wire logic        clk,
  // serial line and its bit time in clocks
  input  wire logic        txd,
  input  wire logic [15:0] bit_cyc,
  // record status
  output int               rec_cnt,
  output int               rec_len,
  output int               rec_start,
  output int               raw_len,
  output int               ferr
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef enum logic [1:0] {PRF_RX_DAT, PRF_RX_DLE, PRF_RX_ETX} prf_rx_t;

  logic [7:0] que [256];
  logic [7:0] b;
  prf_rx_t    st;
  int         ptr;
  int         n;
  int         raw;

  initial begin
    rec_cnt = 0;
    rec_len = 0;
    rec_start = 0;
    raw_len = 0;
    ferr = 0;
    ptr = 0;
    n = 0;
    raw = 0;
    st = PRF_RX_DAT;
    forever begin
      @(negedge txd);
      // sample mid-bit on the falling clock, away from the launch edge
      repeat (bit_cyc / 2) @(negedge clk);
      if (txd !== 1'b0) continue;
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(negedge clk);
        b[i] = txd;
      end
      repeat (bit_cyc) @(negedge clk);
      if (txd !== 1'b1) ferr++;
      raw++;
      case (st)
        PRF_RX_DAT: begin
          if (b == 8'h10) begin
            st = PRF_RX_DLE;
          end else begin
            que[ptr] = b;
            ptr = (ptr + 1) % 256;
            n++;
          end
        end
        PRF_RX_DLE: begin
          if (b == 8'h03) begin
            st = PRF_RX_ETX;
            rec_len = n;
            raw_len = raw;
            raw = 0;
            n = 0;
            rec_cnt++;
            rec_start = ptr;
          end else begin
            st = PRF_RX_DAT;
            que[ptr] = b;
            ptr = (ptr + 1) % 256;
            n++;
          end
        end
        default: begin
          if (b == 8'h10) st = PRF_RX_DLE;
        end
      endcase
    end
  end
endmodule

/* File: sim/prf_framer_bench.sv */
module prf_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SEC = 7000;
  localparam int BF  = 2;
  localparam int BS  = 4;
  localparam int TD  = 1;

  typedef struct {
    logic [2:0] fix;
    logic [7:0] exp;
  } prf_row_t;

  logic        clk;
  logic        srst;
  logic        phase_mode;
  logic [2:0]  fix_code;
  logic        corr_seen;
  logic        corr_slow;
  logic        pay_rd;
  logic        pay_rec;
  logic [7:0]  pay_idx;
  logic [7:0]  pay_data = 8'h00;
  logic        text_en;
  logic        rec_done;
  logic        txd;
  logic [15:0] host_bit_cyc;
  int          rec_cnt;
  int          rec_len;
  int          rec_start;
  int          raw_len;
  int          ferr;
  int          failures;
  int          num_checks;
  int          done_cnt = 0;
  int          c0;
  prf_row_t    rows [6];

  prf_framer #(.SEC_CYCLES(SEC), .BIT_CYC_FAST(BF), .BIT_CYC_SLOW(BS))
  prf_framer_inst (.clk(clk), .srst(srst), .phase_mode(phase_mode),
    .fix_code(fix_code), .corr_seen(corr_seen), .corr_slow(corr_slow),
    .pay_rd(pay_rd), .pay_rec(pay_rec), .pay_idx(pay_idx),
    .pay_data(pay_data), .text_en(text_en), .rec_done(rec_done), .txd(txd));

  prf_host_model prf_host_model_inst (.clk(clk), .txd(txd),
    .bit_cyc(host_bit_cyc), .rec_cnt(rec_cnt), .rec_len(rec_len),
    .rec_start(rec_start), .raw_len(raw_len), .ferr(ferr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // payload source: answers one cycle late, scrambles otherwise
  // ****************************************************************
  function automatic logic [7:0] src_byte(input logic rec,
                                          input logic [7:0] idx);
    if (!rec) return idx + 8'h01;
    return (idx % 5 == 0) ? 8'h00 : (idx ^ 8'h5a);
  endfunction

  function automatic logic [7:0] exp_byte(input logic rec,
                                          input logic [7:0] idx,
                                          input logic [7:0] fx);
    int o;
    o = (int'(idx) + 8) % 18;
    if (!rec) return (idx == 8'h10) ? fx :
                     (idx == 8'h11) ? 8'h00 : src_byte(rec, idx);
    if (idx < 8'h0a) return src_byte(rec, idx);
    if (o == 14 || o == 17) return {7'h00, src_byte(rec, idx) != 8'h00};
    if (o == 16) return src_byte(rec, idx) & 8'h1f;
    return src_byte(rec, idx);
  endfunction

  always @(posedge clk) begin
    pay_data <= #TD pay_rd ? src_byte(pay_rec, pay_idx) : ~pay_data;
    if (rec_done === 1'b1) done_cnt++;
  end

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_rec(input int lim);
    int c;
    c = rec_cnt;
    for (int i = 0; i < lim && rec_cnt == c; i++) @(posedge clk);
    if (rec_cnt == c) begin
      failures++;
      $display("CHECK FAILED record wait expected record seen none");
      tally_and_finish();
    end
    #TD;
  endtask

  task automatic check_rec(input logic rec, input logic [7:0] fx);
    logic [7:0] b;
    logic [7:0] sum;
    int         bad;
    int         dle;
    sum = 8'h00;
    bad = 0;
    dle = 0;
    for (int k = 0; k < rec_len; k++) begin
      b = prf_host_model_inst.que[(rec_start + 256 - rec_len + k) % 256];
      sum = sum + b;
      if (b == 8'h10) dle++;
      if (k == 0) check("type", b, rec ? 8'h34 : 8'h33);
      if (k == 1) check("length", b, rec ? 8'he2 : 8'h40);
      if (k >= 2 && k < rec_len - 1 && b !== exp_byte(rec, 8'(k - 2), fx))
        bad++;
    end
    check("stored count", rec_len, rec ? 229 : 67);
    check("byte sum", sum, 8'h00);
    check("payload mismatches", bad, 0);
    check("line chars", raw_len, rec_len + dle + 3);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rows = '{'{3'h0, 8'h00}, '{3'h1, 8'h01}, '{3'h4, 8'h04},
             '{3'h5, 8'h05}, '{3'h6, 8'h00}, '{3'h7, 8'h00}};
    srst = 1'b1;
    phase_mode = 1'b0;
    fix_code = 3'h0;
    corr_seen = 1'b0;
    corr_slow = 1'b0;
    host_bit_cyc = 16'(BF);
    failures = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    #TD;
    check("reset txd", txd, 1'b1);
    check("reset text_en", text_en, 1'b1);
    check("reset pay_rd", pay_rd, 1'b0);
    check("reset rec_done", rec_done, 1'b0);
    srst = 1'b0;
    phase_mode = 1'b1;
    // a correction at the fast rate must leave the default rate in place
    corr_seen = 1'b1;
    @(posedge clk);
    #TD;
    corr_seen = 1'b0;
    @(posedge clk);
    #TD;
    check("text_en in phase mode", text_en, 1'b0);
    $display("reset test done");
    foreach (rows[r]) begin
      fix_code = rows[r].fix;
      wait_rec(2 * SEC);
      check_rec(1'b0, rows[r].exp);
      wait_rec(SEC);
      check_rec(1'b1, 8'h00);
      $display("row %0d done", r);
    end
    // mode off: no records, text output allowed again
    phase_mode = 1'b0;
    c0 = rec_cnt;
    repeat (SEC + SEC / 4) @(posedge clk);
    #TD;
    check("text_en off mode", text_en, 1'b1);
    check("records while off", rec_cnt, c0);
    $display("mode off test done");
    // corrections at the slower rate move the output to that rate
    phase_mode = 1'b1;
    corr_seen = 1'b1;
    corr_slow = 1'b1;
    host_bit_cyc = 16'(BS);
    @(posedge clk);
    #TD;
    corr_seen = 1'b0;
    corr_slow = 1'b0;
    wait_rec(3 * SEC);
    check_rec(1'b0, 8'h00);
    wait_rec(2 * SEC);
    check_rec(1'b1, 8'h00);
    $display("rate switch test done");
    check("framing errors", ferr, 0);
    check("record done pulses", done_cnt, rec_cnt);
    tally_and_finish();
  end
endmodule
